// >>> rtl/rms_power_device.sv
// Metering end: rms gain and offset correction and per-phase active power
`timescale 1ns/1ps
module rms_power_device
  import rms_power_pkg::*;
(
  reg_link_if.device link,
  input wire logic [PHASES-1:0][V_W-1:0] v_sample,
  input wire logic [PHASES-1:0][I_W-1:0] i_sample,
  input wire logic sample_valid,
  input wire logic [PHASES-1:0] phase_enable,
  output logic [PHASES-1:0][RMS_W-1:0] current_rms,
  output logic [PHASES-1:0][POWER_W-1:0] active_power,
  output logic [TOTAL_W-1:0] total_power,
  output logic rms_update
);
  typedef struct packed {
    logic [PHASES-1:0][GAIN_W-1:0] power_gain;
    logic [PHASES-1:0][GAIN_W-1:0] current_rms_offset;
    logic [PHASES-1:0][GAIN_W-1:0] voltage_gain;
    logic [PHASES-1:0][GAIN_W-1:0] voltage_rms_offset;
    logic [PHASES-1:0][VMS_W-1:0] vms;
    logic [PHASES-1:0][IMS_W-1:0] ims;
    logic [PHASES-1:0][POWER_W-1:0] power;
    logic [TOTAL_W-1:0] total;
    logic [PHASES-1:0][RMS_W-1:0] voltage_rms;
    logic [PHASES-1:0][RMS_W-1:0] current_rms;
    sq_s [2*PHASES-1:0] eng;
    logic [3:0] cnt;
    logic upd;
    logic [RMS_W-1:0] rdata;
    logic rvalid;
  } dev_s;

  dev_s state_reg;
  dev_s state_next;

  // One plus gain over 4096 as a signed factor
  function automatic logic signed [13:0] gain_factor(input logic [GAIN_W-1:0] g);
    return GAIN_ONE + {{2{g[GAIN_W-1]}}, g};
  endfunction

  // Sample times gain factor, back to sample scale
  function automatic logic signed [I_W:0] scale(input logic signed [I_W-1:0] x,
                                                input logic [GAIN_W-1:0] g);
    logic signed [I_W+13:0] p;
    p = x * gain_factor(g);
    return p[I_W+GAIN_SHIFT:GAIN_SHIFT];
  endfunction

  // First order lowpass keeps the dc part of its input
  function automatic logic signed [LP_W-1:0] lowpass(input logic signed [LP_W-1:0] acc,
                                                     input logic signed [LP_W-1:0] x);
    return acc + ((x - acc) >>> LOWPASS_SHIFT);
  endfunction

  // One bit of a restoring square root
  function automatic sq_s sq_step(input sq_s s);
    sq_s o;
    logic [REM_W-1:0] t;
    logic [REM_W-1:0] trial;
    t = {s.rem[REM_W-3:0], s.rad[RAD_W-1 -: 2]};
    trial = {2'b00, s.root, 2'b01};
    o.rad = {s.rad[RAD_W-3:0], 2'b00};
    if (t >= trial) begin
      o.rem = t - trial;
      o.root = {s.root[RMS_W-2:0], 1'b1};
    end else begin
      o.rem = t;
      o.root = {s.root[RMS_W-2:0], 1'b0};
    end
    return o;
  endfunction

  logic signed [I_W:0] vs;
  logic signed [I_W:0] istar;
  logic signed [2*I_W+1:0] vsq;
  logic signed [2*I_W-1:0] isq;
  logic signed [POWER_W-1:0] pinst;
  logic [V_RMS_SHIFT+VMS_W-1:0] vwide;
  logic signed [63:0] iwide;
  logic signed [RMS_W+1:0] vfix;
  logic signed [TOTAL_W-1:0] sum;
  sq_s done_v;
  sq_s done_i;

  // Next state of the whole datapath
  always_comb begin
    state_next = state_reg;
    vs = '0;
    istar = '0;
    vsq = '0;
    isq = '0;
    pinst = '0;
    vwide = '0;
    iwide = '0;
    vfix = '0;
    sum = '0;
    done_v = '0;
    done_i = '0;
    state_next.upd = (state_reg.cnt == UPDATE_LAST);
    state_next.cnt = (state_reg.cnt == UPDATE_LAST) ? 4'h0 : state_reg.cnt + 4'h1;
    for (int ph = 0; ph < PHASES; ph++) begin
      // Voltage gain applied ahead of the rms path
      vs = scale({{(I_W-V_W){v_sample[ph][V_W-1]}}, v_sample[ph]},
                 state_reg.voltage_gain[ph]);
      istar = scale(i_sample[ph], state_reg.power_gain[ph]);
      vsq = vs * vs;
      isq = $signed(i_sample[ph]) * $signed(i_sample[ph]);
      pinst = $signed(v_sample[ph]) * istar;
      if (sample_valid) begin
        state_next.vms[ph] = VMS_W'(lowpass(LP_W'($signed({1'b0, state_reg.vms[ph]})),
                                            LP_W'(vsq)));
        state_next.ims[ph] = IMS_W'(lowpass(LP_W'($signed({1'b0, state_reg.ims[ph]})),
                                            LP_W'(isq)));
        state_next.power[ph] = POWER_W'(lowpass(LP_W'($signed(state_reg.power[ph])),
                                                LP_W'(pinst)));
      end
      if (phase_enable[ph]) begin
        sum = sum + TOTAL_W'($signed(state_reg.power[ph]));
      end
      // Both root engines take two bits per clock
      done_v = sq_step(sq_step(state_reg.eng[ph]));
      done_i = sq_step(sq_step(state_reg.eng[ph+PHASES]));
      state_next.eng[ph] = done_v;
      state_next.eng[ph+PHASES] = done_i;
      if (state_reg.cnt == UPDATE_LAST) begin
        // Voltage root plus offset times 64, held in 0 to full scale
        vfix = $signed({2'b00, done_v.root})
             + ($signed(state_reg.voltage_rms_offset[ph]) <<< V_OFF_SHIFT);
        if (vfix < 0) begin
          state_next.voltage_rms[ph] = '0;
        end else if (vfix[RMS_W]) begin
          state_next.voltage_rms[ph] = '1;
        end else begin
          state_next.voltage_rms[ph] = vfix[RMS_W-1:0];
        end
        state_next.current_rms[ph] = done_i.root;
        // Mean square times 65536 gives 256 counts per sample count
        vwide = {state_reg.vms[ph], {V_RMS_SHIFT{1'b0}}};
        state_next.eng[ph] = '0;
        state_next.eng[ph].rad = (|vwide[V_RMS_SHIFT+VMS_W-1:RAD_W]) ? '1
                               : vwide[RAD_W-1:0];
        // Gain under the root, then offset times 32768
        iwide = (64'($signed({1'b0, state_reg.ims[ph]})) * 64'(gain_factor(
                  state_reg.power_gain[ph]))) >>> GAIN_SHIFT;
        iwide = iwide + (64'($signed(state_reg.current_rms_offset[ph]))
                         <<< I_OFF_SHIFT);
        state_next.eng[ph+PHASES] = '0;
        if (iwide < 0) begin
          state_next.eng[ph+PHASES].rad = '0;
        end else if (|iwide[63:RAD_W]) begin
          state_next.eng[ph+PHASES].rad = '1;
        end else begin
          state_next.eng[ph+PHASES].rad = iwide[RAD_W-1:0];
        end
      end
    end
    state_next.total = sum;
    // Register writes
    if (link.reg_wr) begin
      for (int ph = 0; ph < PHASES; ph++) begin
        if (link.reg_addr == ADDR_POWER_GAIN + ADDR_W'(ph)) begin
          state_next.power_gain[ph] = link.reg_wdata;
        end else if (link.reg_addr == ADDR_CURRENT_RMS_OFFSET + ADDR_W'(ph)) begin
          state_next.current_rms_offset[ph] = link.reg_wdata;
        end else if (link.reg_addr == ADDR_VOLTAGE_GAIN + ADDR_W'(ph)) begin
          state_next.voltage_gain[ph] = link.reg_wdata;
        end else if (link.reg_addr == ADDR_VOLTAGE_RMS_OFFSET + ADDR_W'(ph)) begin
          state_next.voltage_rms_offset[ph] = link.reg_wdata;
        end
      end
    end
    // Register reads answer one clock later, unmapped reads give zero
    state_next.rvalid = link.reg_rd;
    if (link.reg_rd) begin
      state_next.rdata = '0;
      for (int ph = 0; ph < PHASES; ph++) begin
        if (link.reg_addr == ADDR_POWER_GAIN + ADDR_W'(ph)) begin
          state_next.rdata = {12'h000, state_reg.power_gain[ph]};
        end else if (link.reg_addr == ADDR_CURRENT_RMS_OFFSET + ADDR_W'(ph)) begin
          state_next.rdata = {12'h000, state_reg.current_rms_offset[ph]};
        end else if (link.reg_addr == ADDR_VOLTAGE_RMS + ADDR_W'(ph)) begin
          state_next.rdata = state_reg.voltage_rms[ph];
        end else if (link.reg_addr == ADDR_VOLTAGE_GAIN + ADDR_W'(ph)) begin
          state_next.rdata = {12'h000, state_reg.voltage_gain[ph]};
        end else if (link.reg_addr == ADDR_VOLTAGE_RMS_OFFSET + ADDR_W'(ph)) begin
          state_next.rdata = {12'h000, state_reg.voltage_rms_offset[ph]};
        end
      end
    end
  end

  // State register, every field clears on reset
  always_ff @(posedge link.clock) begin
    if (link.rst) begin
      state_reg <= '0;
      for (int ph = 0; ph < PHASES; ph++) begin
        state_reg.power_gain[ph] <= GAIN_RESET;
        state_reg.voltage_gain[ph] <= GAIN_RESET;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign link.reg_rdata = state_reg.rdata;
  assign link.reg_rvalid = state_reg.rvalid;
  assign current_rms = state_reg.current_rms;
  assign active_power = state_reg.power;
  assign total_power = state_reg.total;
  assign rms_update = state_reg.upd;
endmodule

// >>> rtl/rms_power_pkg.sv
// Shared constants and types for the rms correction and active power ends
// Functional notes
// - Power gain scales current rms by sqrt
// - Twelve-bit signed current rms offset per phase
// - Current rms: sqrt(raw squared plus offset*32768)
// - Voltage rms taken after voltage gain scaling
// - Voltage gain scales linearly, plus/minus half
// - Voltage rms stored unsigned 24-bit
// - Voltage rms refreshed every twelve clocks
// - 256 voltage rms counts per sample count
// - Voltage rms plus offset times 64
// - Power: voltage times current, lowpass filtered
// - Total power sums enabled phases only
// - Controller scales current rms per phase itself
// - Controller scales voltage rms per phase itself
// - Current offset from full and hundredth scale
// - Voltage offset from full and tenth scale
// - Current rms unsigned 24-bit, twelve-clock refresh
package rms_power_pkg;
  localparam int PHASES = 3;
  localparam int V_W = 16;
  localparam int I_W = 24;
  localparam int GAIN_W = 12;
  localparam int RMS_W = 24;
  localparam int RAD_W = 48;
  localparam int REM_W = 28;
  localparam int VMS_W = 34;
  localparam int IMS_W = 48;
  localparam int POWER_W = 41;
  localparam int TOTAL_W = 43;
  localparam int ADDR_W = 4;
  localparam int LP_W = 50;
  // Gain of one is 4096, gain value is a fraction of it
  localparam logic signed [13:0] GAIN_ONE = 14'sh1000;
  localparam int GAIN_SHIFT = 12;
  localparam int I_OFF_SHIFT = 15;
  localparam int V_OFF_SHIFT = 6;
  localparam int V_RMS_SHIFT = 16;
  localparam int LOWPASS_SHIFT = 8;
  // Results refresh every twelve clocks, two root bits per clock
  localparam logic [3:0] UPDATE_LAST = 4'hb;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h000;
  // Register indices on the register port
  localparam logic [ADDR_W-1:0] ADDR_POWER_GAIN = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT_RMS_OFFSET = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_VOLTAGE_RMS = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_VOLTAGE_GAIN = 4'h9;
  localparam logic [ADDR_W-1:0] ADDR_VOLTAGE_RMS_OFFSET = 4'hc;
  // One square root engine
  typedef struct packed {
    logic [REM_W-1:0] rem;
    logic [RMS_W-1:0] root;
    logic [RAD_W-1:0] rad;
  } sq_s;
  typedef enum logic [0:0] {
    HOST_IDLE = 1'b0,
    HOST_WAIT = 1'b1
  } host_state_e;
endpackage

// >>> rtl/reg_link_if.sv
// Register port between the controller and the metering datapath
`timescale 1ns/1ps
interface reg_link_if
  import rms_power_pkg::*;
(
  input logic clock,
  input logic rst
);
  logic [ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [GAIN_W-1:0] reg_wdata;
  logic [RMS_W-1:0] reg_rdata;
  logic reg_rvalid;
  modport device (
    input clock,
    input rst,
    input reg_addr,
    input reg_wr,
    input reg_rd,
    input reg_wdata,
    output reg_rdata,
    output reg_rvalid
  );
  modport host (
    input clock,
    input rst,
    output reg_addr,
    output reg_wr,
    output reg_rd,
    output reg_wdata,
    input reg_rdata,
    input reg_rvalid
  );
endinterface

// >>> rtl/rms_power_host.sv
// Controller end: turns user commands into register port accesses
`timescale 1ns/1ps
module rms_power_host
  import rms_power_pkg::*;
(
  reg_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [GAIN_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [RMS_W-1:0] resp_data
);
  typedef struct packed {
    host_state_e st;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [GAIN_W-1:0] wdata;
    logic ready;
    logic resp_valid;
    logic [RMS_W-1:0] resp_data;
  } host_s;

  host_s state_reg;
  host_s state_next;

  // One access at a time; strobes last one clock
  always_comb begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;
    state_next.resp_valid = 1'b0;
    case (state_reg.st)
      HOST_IDLE: begin
        if (cmd_valid && state_reg.ready) begin
          state_next.addr = cmd_addr;
          state_next.wdata = cmd_wdata;
          state_next.wr = cmd_write;
          state_next.rd = !cmd_write;
          state_next.ready = 1'b0;
          state_next.st = HOST_WAIT;
        end
      end
      HOST_WAIT: begin
        if (state_reg.addr != ADDR_POWER_GAIN && !state_reg.rd && !link.reg_rvalid
            && state_reg.wr == 1'b0 && state_reg.resp_valid == 1'b0
            && state_reg.ready == 1'b0 && !state_reg.rd) begin
          // Write finished once its strobe has gone out
          state_next.ready = 1'b1;
          state_next.st = HOST_IDLE;
        end
        if (state_reg.addr == ADDR_POWER_GAIN && !state_reg.wr && !state_reg.rd
            && !link.reg_rvalid) begin
          state_next.ready = 1'b1;
          state_next.st = HOST_IDLE;
        end
        if (link.reg_rvalid) begin
          // Raw rms counts go back; unit scaling per phase is firmware work
          state_next.resp_data = link.reg_rdata;
          state_next.resp_valid = 1'b1;
          state_next.ready = 1'b1;
          state_next.st = HOST_IDLE;
        end
      end
      default: begin
        state_next.st = HOST_IDLE;
      end
    endcase
  end

  // State register; ready is already high while reset is held
  always_ff @(posedge link.clock) begin
    if (link.rst) begin
      state_reg <= '0;
      state_reg.ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Offsets computed from two-level measurements arrive as plain writes
  assign link.reg_addr = state_reg.addr;
  assign link.reg_wr = state_reg.wr;
  assign link.reg_rd = state_reg.rd;
  assign link.reg_wdata = state_reg.wdata;
  assign cmd_ready = state_reg.ready;
  assign resp_valid = state_reg.resp_valid;
  assign resp_data = state_reg.resp_data;
endmodule

// >>> tb/rms_link_sva.sv
// Concurrent checks on the register port between the two ends
`timescale 1ns/1ps
module rms_link_sva
  import rms_power_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [GAIN_W-1:0] reg_wdata,
  input wire logic [RMS_W-1:0] reg_rdata,
  input wire logic reg_rvalid
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic [15:0][GAIN_W-1:0] shadow_reg;
  logic [RMS_W-1:0] expect_reg;
  logic known_reg;
  logic stored;
  // Result places and the unused index keep no shadow copy
  assign stored = reg_addr < 4'h6 || (reg_addr > 4'h8 && reg_addr != 4'hf);
  // Shadow of writable places and the value the next answer must carry
  always_ff @(posedge clock) begin
    if (rst) begin
      shadow_reg <= '0;
      expect_reg <= '0;
      known_reg <= 1'b0;
    end else begin
      if (reg_wr && stored) begin
        shadow_reg[reg_addr] <= reg_wdata;
      end
      if (reg_rd) begin
        expect_reg <= {12'h000, shadow_reg[reg_addr]};
        known_reg <= stored || reg_addr == 4'hf;
      end
    end
  end
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without a read");
  answer_pulse_a: assert property (reg_rvalid |=> !reg_rvalid)
    else $error("answer longer than one cycle");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  reg_readback_a: assert property (reg_rvalid && known_reg |-> reg_rdata == expect_reg)
    else $error("read data differs from last write");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 4'hf |=> reg_rdata == '0)
    else $error("unused index not zero");
  strobe_excl_a: assert property (!(reg_wr && reg_rd))
    else $error("write and read together");
  strobe_space_a: assert property ((reg_wr || reg_rd) |=> !(reg_wr || reg_rd) [*2])
    else $error("strobes too close");
  cover property (reg_wr && reg_addr == ADDR_VOLTAGE_GAIN);
  cover property (reg_rvalid && reg_rdata != '0);
  cover property (reg_rd && reg_addr == 4'hf);
endmodule

// >>> tb/tb_top.sv
// Bench joining the controller and metering ends over the register port
`timescale 1ns/1ps
module tb_top
  import rms_power_pkg::*;
;
  localparam int PG[3] = '{0, 2047, -2048};
  localparam int VG[3] = '{0, 1024, -1024};
  logic clock, rst, sample_valid, rms_update;
  logic cmd_valid, cmd_write, cmd_ready, resp_valid;
  logic [ADDR_W-1:0] cmd_addr;
  logic [GAIN_W-1:0] cmd_wdata;
  logic [RMS_W-1:0] resp_data, q;
  logic [PHASES-1:0] phase_enable;
  logic [PHASES-1:0][V_W-1:0] v_sample;
  logic [PHASES-1:0][I_W-1:0] i_sample;
  logic [PHASES-1:0][RMS_W-1:0] current_rms;
  logic [PHASES-1:0][POWER_W-1:0] active_power;
  logic [TOTAL_W-1:0] total_power;
  int errors, compares, n;
  real e;
  reg_link_if reg_link_if_i (.clock(clock), .rst(rst));
  rms_power_host rms_power_host_i (.link(reg_link_if_i), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data));
  rms_power_device rms_power_device_i (.link(reg_link_if_i), .v_sample(v_sample),
    .i_sample(i_sample), .sample_valid(sample_valid), .phase_enable(phase_enable),
    .current_rms(current_rms), .active_power(active_power),
    .total_power(total_power), .rms_update(rms_update));
  rms_link_sva rms_link_sva_i (.clock(clock), .rst(rst),
    .reg_addr(reg_link_if_i.reg_addr), .reg_wr(reg_link_if_i.reg_wr),
    .reg_rd(reg_link_if_i.reg_rd), .reg_wdata(reg_link_if_i.reg_wdata),
    .reg_rdata(reg_link_if_i.reg_rdata), .reg_rvalid(reg_link_if_i.reg_rvalid));
  // Clock at 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Verdict and end of run
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare and count
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Within half a percent, with a small floor for rounding
  function automatic bit close(input real s, input real x);
    return (s - x <= x * 0.005 + 4.0) && (x - s <= x * 0.005 + 4.0);
  endfunction
  // One command, held until taken; a read then waits for its answer
  task automatic access(input logic wr_op, input logic [3:0] a, input logic [11:0] d);
    int k;
    k = 0;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= wr_op;
    cmd_addr <= a;
    cmd_wdata <= d;
    // Outputs are looked at mid-cycle, where they have settled
    do begin
      @(negedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 50);
    @(posedge clock);
    cmd_valid <= 1'b0;
    if (!wr_op) begin
      do begin
        @(negedge clock);
        k++;
      end while (resp_valid !== 1'b1 && k < 50);
      q = resp_data;
      @(posedge clock);
    end
    if (k >= 50) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input int a, input int d);
    access(1'b1, a[3:0], d[11:0]);
  endtask
  task automatic rd_chk(input int a, input logic [RMS_W-1:0] x);
    access(1'b0, a[3:0], 12'h000);
    check(q, x);
  endtask
  // Wait for a number of result refreshes, bounded per refresh
  task automatic wait_upd(input int c);
    int k;
    k = 0;
    while (c > 0 && k < 100) begin
      @(negedge clock);
      k++;
      if (rms_update === 1'b1) begin
        c--;
        k = 0;
      end
    end
    if (c > 0) begin
      errors++;
      print_verdict();
    end
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    sample_valid = 1'b0;
    phase_enable = 3'b000;
    v_sample = '0;
    i_sample = '0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 4'h0;
    cmd_wdata = 12'h000;
    errors = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    // Every index reads zero after reset, the unused one included
    for (int a = 0; a < 16; a++) begin
      rd_chk(a, 24'h000000);
    end
    // Boundary values stick in gain and current offset places, result places ignore writes
    for (int a = 0; a < 12; a++) begin
      wr(a, a[0] ? 12'h7ff : 12'h800);
    end
    for (int a = 0; a < 15; a++) begin
      rd_chk(a, (a > 5 && a < 9) || a > 11 ? 24'h0 : (a[0] ? 24'h7ff : 24'h800));
    end
    // Offsets alone on idle inputs give exact results, negatives clamp
    wr(ADDR_CURRENT_RMS_OFFSET, 12'h020);
    wr(ADDR_CURRENT_RMS_OFFSET + 1, 12'hfe0);
    wr(ADDR_VOLTAGE_RMS_OFFSET, 12'h010);
    wr(ADDR_VOLTAGE_RMS_OFFSET + 1, 12'hff0);
    wait_upd(3);
    check(current_rms[0], 24'h000400);
    check(current_rms[1], 24'h000000);
    rd_chk(ADDR_VOLTAGE_RMS, 24'h000400);
    rd_chk(ADDR_VOLTAGE_RMS + 1, 24'h000000);
    // Gains on live inputs scale rms and power per phase
    for (int p = 0; p < 3; p++) begin
      wr(ADDR_POWER_GAIN + p, PG[p]);
      wr(ADDR_VOLTAGE_GAIN + p, VG[p]);
      wr(ADDR_CURRENT_RMS_OFFSET + p, 0);
      wr(ADDR_VOLTAGE_RMS_OFFSET + p, 0);
      v_sample[p] <= 16'(1000 * (p + 1));
      i_sample[p] <= 24'(500 * (p + 1));
    end
    sample_valid <= 1'b1;
    repeat (4000) @(posedge clock);
    wait_upd(2);
    for (int p = 0; p < 3; p++) begin
      access(1'b0, 4'(ADDR_VOLTAGE_RMS + p), 12'h000);
      check(close(q, 256.0 * (p + 1) * 1000 * (4096 + VG[p]) / 4096), 1'b1);
      check(close(current_rms[p], 500.0 * (p + 1) * $sqrt((4096.0 + PG[p]) / 4096)), 1'b1);
      check(close($signed(active_power[p]), 5.0e5 * (p + 1) * (p + 1) * (4096 + PG[p]) / 4096),
        1'b1);
    end
    // Every enable pattern sums exactly the chosen phases
    for (int m = 0; m < 8; m++) begin
      phase_enable <= 3'(m);
      repeat (3) @(posedge clock);
      e = 0.0;
      for (int p = 0; p < 3; p++) begin
        if (m[p]) begin
          e += 5.0e5 * (p + 1) * (p + 1) * (4096 + PG[p]) / 4096;
        end
      end
      check(close($signed(total_power), e), 1'b1);
    end
    // Results refresh every twelve clocks
    wait_upd(1);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (rms_update !== 1'b1 && n < 100);
    check(n, 12);
    print_verdict();
  end
endmodule
